//--- hdl/motor_run_statistics_recorder.sv
// Motor run statistics recorder: start current, start time, extremes,
// energy, start count, temperatures, hour counters, changed parameters.
// Assumes every input comes from logic on i_clk; retention across power
// loss is by an outside backup of the outputs.
`timescale 1ns/1ps
module motor_run_statistics_recorder #(
   parameter int unsigned SEC_CYCLES = stats_pkg::SEC_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_start_begin,
   input wire logic i_start_end,
   input wire logic i_test_passed,
   input wire logic i_inching,
   input wire logic i_full_voltage,
   input wire logic i_motor_running,
   input wire logic i_fan_on,
   input wire logic i_cur_valid,
   input wire logic [stats_pkg::MEAS_W-1:0] i_cur_sample,
   input wire logic i_line_valid,
   input wire logic [stats_pkg::MEAS_W-1:0] i_volt_sample,
   input wire logic [stats_pkg::MEAS_W-1:0] i_freq_sample,
   input wire logic i_energy_step,
   input wire logic i_temp_valid,
   input wire logic [stats_pkg::MEAS_W-1:0] i_scr_temp,
   input wire logic [stats_pkg::N_MTEMP*stats_pkg::MEAS_W-1:0]
      i_motor_temp,
   input wire logic [stats_pkg::SEL_W-1:0] i_statistics_clear_selector,
   input wire logic i_clear_strobe,
   input wire logic i_scan_start,
   input wire logic [stats_pkg::N_PARAM*stats_pkg::PARAM_W-1:0]
      i_param_values,
   output logic [stats_pkg::MEAS_W-1:0] o_start_cur_max,
   output logic [stats_pkg::MEAS_W-1:0] o_start_cur_avg,
   output logic [stats_pkg::TIME_W-1:0] o_start_time_actual,
   output logic [stats_pkg::TIME_W-1:0] o_start_time_final,
   output logic [stats_pkg::MEAS_W-1:0] o_fullv_cur_max,
   output logic [stats_pkg::MEAS_W-1:0] o_volt_max,
   output logic [stats_pkg::MEAS_W-1:0] o_volt_min,
   output logic [stats_pkg::MEAS_W-1:0] o_freq_max,
   output logic [stats_pkg::MEAS_W-1:0] o_freq_min,
   output logic [31:0] o_energy,
   output logic [15:0] o_start_count,
   output logic [stats_pkg::MEAS_W-1:0] o_scr_temp_max,
   output logic [stats_pkg::N_MTEMP*stats_pkg::MEAS_W-1:0]
      o_motor_temp_max,
   output logic [31:0] o_powered_time,
   output logic [31:0] o_motor_run_time_counter,
   output logic [31:0] o_fan_run_time_counter,
   output logic o_changed_valid,
   output logic [stats_pkg::PIDX_W-1:0] o_changed_idx,
   output logic o_scan_busy,
   output logic o_scan_done
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      stats_pkg::phase_t phase;
      logic [stats_pkg::SUM_W-1:0] sum;
      logic [stats_pkg::NSAMP_W-1:0] n;
      logic [stats_pkg::MEAS_W-1:0] avg;
      logic [stats_pkg::TIME_W-1:0] t_act;
      logic [stats_pkg::TIME_W-1:0] t_fin;
      logic [15:0] starts;
      logic [31:0] energy;
      logic [31:0] powered;
      logic [31:0] run;
      logic [31:0] fan;
      logic scan_busy;
      logic [stats_pkg::PIDX_W-1:0] scan_idx;
      logic chg_valid;
      logic [stats_pkg::PIDX_W-1:0] chg_idx;
      logic scan_done;
   } rec_state_t;
   rec_state_t st;
   rec_state_t next_st;
   logic tick;
   logic clr_stats;
   logic clr_scr;
   logic clr_hours;
   logic cur_ok;
   logic [stats_pkg::PARAM_W-1:0] param_now;
   logic [stats_pkg::NTRK-1:0] trk_valid;
   logic [stats_pkg::NTRK-1:0] trk_clear;
   logic [stats_pkg::NTRK-1:0][stats_pkg::MEAS_W-1:0] trk_sample;
   // Clear selector write with a given code
   function automatic logic clear_hit(input logic strobe,
      input logic [stats_pkg::SEL_W-1:0] sel,
      input logic [stats_pkg::SEL_W-1:0] code);
      return strobe && (sel == code);
   endfunction: clear_hit
   // Counter that sticks at full scale instead of wrapping
   function automatic logic [31:0] sat_inc32(input logic [31:0] v);
      return (v == stats_pkg::COUNT32_MAX) ? v : v + 32'h1;
   endfunction: sat_inc32
   second_ticker #(.CYCLES(SEC_CYCLES)) u_tick (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .o_tick(tick)
   );
   // ****************************************
   // Extreme trackers
   // ****************************************
   // Decode the clear codes once for every tracker and counter
   always_comb begin
      clr_stats = clear_hit(i_clear_strobe, i_statistics_clear_selector,
         stats_pkg::CLR_STATS);
      clr_scr = clear_hit(i_clear_strobe, i_statistics_clear_selector,
         stats_pkg::CLR_SCR);
      clr_hours = clear_hit(i_clear_strobe, i_statistics_clear_selector,
         stats_pkg::CLR_HOURS);
   end
   // Start samples skip the begin cycle so the zeroing is never undone
   assign cur_ok = i_cur_valid && !i_inching && !i_start_begin &&
      (st.phase == stats_pkg::PH_START);
   // Qualify, route and clear each tracker
   always_comb begin
      trk_valid = '0;
      trk_clear = {stats_pkg::NTRK{clr_stats}};
      trk_sample[stats_pkg::T_SCUR] = i_cur_sample;
      trk_valid[stats_pkg::T_SCUR] = cur_ok;
      trk_clear[stats_pkg::T_SCUR] = i_start_begin;
      trk_sample[stats_pkg::T_FCUR] = i_cur_sample;
      trk_valid[stats_pkg::T_FCUR] = i_cur_valid && i_full_voltage;
      trk_sample[stats_pkg::T_VMAX] = i_volt_sample;
      trk_sample[stats_pkg::T_VMIN] = i_volt_sample;
      trk_valid[stats_pkg::T_VMAX] = i_line_valid && i_motor_running;
      trk_valid[stats_pkg::T_VMIN] = i_line_valid && i_motor_running;
      trk_sample[stats_pkg::T_FMAX] = i_freq_sample;
      trk_sample[stats_pkg::T_FMIN] = i_freq_sample;
      trk_valid[stats_pkg::T_FMAX] = i_line_valid && i_motor_running;
      trk_valid[stats_pkg::T_FMIN] = i_line_valid && i_motor_running;
      trk_sample[stats_pkg::T_SCR] = i_scr_temp;
      trk_valid[stats_pkg::T_SCR] = i_temp_valid;
      trk_clear[stats_pkg::T_SCR] = clr_scr;
      for (int m = 0; m < stats_pkg::N_MTEMP; m++) begin
         trk_sample[stats_pkg::T_MTEMP0 + m] =
            i_motor_temp[m*stats_pkg::MEAS_W +: stats_pkg::MEAS_W];
         trk_valid[stats_pkg::T_MTEMP0 + m] = i_temp_valid;
      end
   end
   stat_trk_if trk [stats_pkg::NTRK] ();
   for (genvar g = 0; g < stats_pkg::NTRK; g++) begin: g_trk
      assign trk[g].sample_valid = trk_valid[g];
      assign trk[g].sample = trk_sample[g];
      assign trk[g].clear = trk_clear[g];
      // Currents, voltage and frequency are unsigned; temperatures signed
      value_tracker #(
         .IS_MAX(stats_pkg::TRK_IS_MAX[g]),
         .IS_SIGNED(g >= stats_pkg::T_SCR)
      ) u_trk (
         .i_clk(i_clk),
         .i_nrst(i_nrst),
         .port(trk[g])
      );
   end
   for (genvar m = 0; m < stats_pkg::N_MTEMP; m++) begin: g_mtemp
      assign o_motor_temp_max[m*stats_pkg::MEAS_W +: stats_pkg::MEAS_W] =
         trk[stats_pkg::T_MTEMP0 + m].stored;
   end

   // ****************************************
   // Start, counters and scan
   // ****************************************
   assign param_now =
      i_param_values[st.scan_idx*stats_pkg::PARAM_W +: stats_pkg::PARAM_W];
   always_comb begin
      next_st = st;
      // Start phase: average and seconds run only while starting
      unique case (st.phase)
         stats_pkg::PH_IDLE: begin
         end
         stats_pkg::PH_START: begin
            if (tick && st.t_act != stats_pkg::START_TIME_MAX) begin
               next_st.t_act = st.t_act + 1'b1;
            end
            if (cur_ok) begin
               next_st.sum = st.sum + stats_pkg::SUM_W'(i_cur_sample);
               next_st.n = st.n + 1'b1;
               // Wide divide, kept since one result per sample suffices
               next_st.avg = stats_pkg::MEAS_W'(next_st.sum /
                  stats_pkg::SUM_W'(next_st.n));
            end
            if (i_start_end) begin
               next_st.t_fin = st.t_act;
               next_st.t_act = '0;
               next_st.phase = stats_pkg::PH_IDLE;
            end
         end
      endcase
      // A new start zeroes everything volatile, even mid-start
      if (i_start_begin) begin
         next_st.phase = stats_pkg::PH_START;
         next_st.sum = '0;
         next_st.n = '0;
         next_st.avg = '0;
         next_st.t_act = '0;
         next_st.t_fin = '0;
         if (i_test_passed && st.starts != stats_pkg::START_COUNT_MAX) begin
            next_st.starts = st.starts + 16'h1;
         end
      end
      // Clear first, then count: an event in the clear cycle survives
      if (clr_stats) begin
         next_st.energy = '0;
      end
      if (i_energy_step) begin
         next_st.energy = sat_inc32(next_st.energy);
      end
      if (clr_hours) begin
         next_st.run = '0;
         next_st.fan = '0;
      end
      if (tick) begin
         next_st.powered = sat_inc32(st.powered);
         if (i_motor_running) begin
            next_st.run = sat_inc32(next_st.run);
         end
         if (i_fan_on) begin
            next_st.fan = sat_inc32(next_st.fan);
         end
      end
      // One parameter compared per cycle
      next_st.chg_valid = 1'b0;
      next_st.scan_done = 1'b0;
      if (st.scan_busy) begin
         next_st.chg_valid = (param_now !=
            stats_pkg::FACTORY_DEFAULT[st.scan_idx]);
         next_st.chg_idx = st.scan_idx;
         next_st.scan_idx = st.scan_idx + 1'b1;
         if (st.scan_idx == stats_pkg::PIDX_LAST) begin
            next_st.scan_busy = 1'b0;
            next_st.scan_done = 1'b1;
         end
      end else if (i_scan_start) begin
         next_st.scan_busy = 1'b1;
         next_st.scan_idx = '0;
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Register-fed outputs
   assign o_start_cur_max = trk[stats_pkg::T_SCUR].stored;
   assign o_fullv_cur_max = trk[stats_pkg::T_FCUR].stored;
   assign o_volt_max = trk[stats_pkg::T_VMAX].stored;
   assign o_volt_min = trk[stats_pkg::T_VMIN].stored;
   assign o_freq_max = trk[stats_pkg::T_FMAX].stored;
   assign o_freq_min = trk[stats_pkg::T_FMIN].stored;
   assign o_scr_temp_max = trk[stats_pkg::T_SCR].stored;
   assign o_start_cur_avg = st.avg;
   assign o_start_time_actual = st.t_act;
   assign o_start_time_final = st.t_fin;
   assign o_start_count = st.starts;
   assign o_energy = st.energy;
   assign o_powered_time = st.powered;
   assign o_motor_run_time_counter = st.run;
   assign o_fan_run_time_counter = st.fan;
   assign o_changed_valid = st.chg_valid;
   assign o_changed_idx = st.chg_idx;
   assign o_scan_busy = st.scan_busy;
   assign o_scan_done = st.scan_done;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   start_zero_a: assert property (i_start_begin |=>
      o_start_time_actual == 0 && o_start_time_final == 0 &&
      o_start_cur_avg == 0 && o_start_cur_max == 0)
      else $error("start values not zeroed at start");
   time_xfer_a: assert property (st.phase == stats_pkg::PH_START &&
      i_start_end && !i_start_begin |=> o_start_time_final ==
      $past(o_start_time_actual) && o_start_time_actual == 0)
      else $error("start time not transferred at start end");
   time_cap_a: assert property (
      o_start_time_actual <= stats_pkg::START_TIME_MAX)
      else $error("start time passed its limit");
   inch_excl_a: assert property (
      i_inching && !i_start_begin |=> $stable(st.n))
      else $error("inching current entered the average");
   count_step_a: assert property (i_start_begin && i_test_passed &&
      o_start_count != 16'hFFFF |=> o_start_count ==
      $past(o_start_count) + 16'h1)
      else $error("start count did not advance");
   count_hold_a: assert property (!(i_start_begin && i_test_passed)
      |=> $stable(o_start_count))
      else $error("start count moved without a start");
   energy_clr_a: assert property (clr_stats |=> o_energy <= 32'h1)
      else $error("energy not cleared by code 5");
   stats_clr_a: assert property (clr_stats && !i_line_valid &&
      !i_cur_valid |=> o_volt_max == 0 && o_freq_min == 0 &&
      o_fullv_cur_max == 0)
      else $error("code 5 left an extreme standing");
   scr_clr_a: assert property (clr_scr && !i_temp_valid |=>
      o_scr_temp_max == 0)
      else $error("code 6 did not clear the SCR maximum");
   hours_clr_a: assert property (clr_hours |=>
      o_motor_run_time_counter <= 32'h1 && o_fan_run_time_counter <= 32'h1
      && o_powered_time >= $past(o_powered_time))
      else $error("code 7 cleared the wrong counters");
   fan_step_a: assert property (tick && i_fan_on && !clr_hours &&
      o_fan_run_time_counter != 32'hFFFFFFFF |=> o_fan_run_time_counter
      == $past(o_fan_run_time_counter) + 32'h1)
      else $error("fan seconds did not advance");
   scan_flag_a: assert property (st.scan_busy |=>
      o_changed_valid == ($past(param_now) !=
      stats_pkg::FACTORY_DEFAULT[$past(st.scan_idx)]) &&
      o_changed_idx == $past(st.scan_idx))
      else $error("changed parameter flag wrong");
   start_done_c: cover property (i_start_begin ##[1:50] i_start_end);
   clear5_c: cover property (clr_stats ##1 o_energy == 0);
   changed_c: cover property (o_changed_valid);
   count_c: cover property (i_start_begin && i_test_passed);
endmodule: motor_run_statistics_recorder

//--- hdl/stats_pkg.sv
// Constants and types shared by the run statistics recorder.
// Assumes a single 200 MHz clock and same-clock measurement inputs.
package stats_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_PERIOD_S;
   localparam int unsigned TICK_CNT_W = 28;
   // ****************************************
   // Widths and limits
   // ****************************************
   localparam int unsigned MEAS_W = 18;
   localparam int unsigned SUM_W = 48;
   localparam int unsigned NSAMP_W = 24;
   localparam int unsigned TIME_W = 10;
   localparam int unsigned SEL_W = 4;
   localparam logic [TIME_W-1:0] START_TIME_MAX = 10'h3E7;
   localparam logic [15:0] START_COUNT_MAX = 16'hFFFF;
   localparam logic [31:0] COUNT32_MAX = 32'hFFFFFFFF;
   // Clear selector codes
   localparam logic [SEL_W-1:0] CLR_STATS = 4'h5;
   localparam logic [SEL_W-1:0] CLR_SCR = 4'h6;
   localparam logic [SEL_W-1:0] CLR_HOURS = 4'h7;
   // ****************************************
   // Extreme trackers
   // ****************************************
   localparam int unsigned NTRK = 13;
   localparam int unsigned T_SCUR = 0;
   localparam int unsigned T_FCUR = 1;
   localparam int unsigned T_VMAX = 2;
   localparam int unsigned T_VMIN = 3;
   localparam int unsigned T_FMAX = 4;
   localparam int unsigned T_FMIN = 5;
   localparam int unsigned T_SCR = 6;
   localparam int unsigned T_MTEMP0 = 7;
   localparam int unsigned N_MTEMP = 6;
   localparam logic [NTRK-1:0] TRK_IS_MAX = 13'h1FD7;
   // ****************************************
   // Changed-parameter scan
   // ****************************************
   localparam int unsigned N_PARAM = 16;
   localparam int unsigned PARAM_W = 16;
   localparam int unsigned PIDX_W = 4;
   localparam logic [PIDX_W-1:0] PIDX_LAST = 4'hF;
   localparam logic [PARAM_W-1:0] FACTORY_DEFAULT [N_PARAM] = '{
      16'h0001, 16'h001E, 16'h0014, 16'h0001, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   typedef enum logic [0:0] {PH_IDLE, PH_START} phase_t;
endpackage: stats_pkg

//--- hdl/stat_trk_if.sv
// Sample, clear and result of one extreme-value tracker.
// Assumes driver and tracker share one clock.
`timescale 1ns/1ps
interface stat_trk_if;
   logic sample_valid;
   logic signed [stats_pkg::MEAS_W-1:0] sample;
   logic clear;
   logic signed [stats_pkg::MEAS_W-1:0] stored;
   modport src (output sample_valid, sample, clear, input stored);
   modport trk (input sample_valid, sample, clear, output stored);
endinterface: stat_trk_if

//--- hdl/second_ticker.sv
// One-cycle pulse once per second.
// Assumes CYCLES is at least 2.
`timescale 1ns/1ps
module second_ticker #(
   parameter int unsigned CYCLES = stats_pkg::SEC_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   output logic o_tick
);
   typedef struct packed {
      logic [stats_pkg::TICK_CNT_W-1:0] cnt;
      logic tick;
   } tick_state_t;
   tick_state_t st;
   tick_state_t next_st;
   localparam logic [stats_pkg::TICK_CNT_W-1:0] LAST =
      stats_pkg::TICK_CNT_W'(CYCLES - 1);

   // Free-running divider
   always_comb begin
      next_st = st;
      next_st.tick = (st.cnt == LAST);
      next_st.cnt = (st.cnt == LAST) ? '0 : st.cnt + 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign o_tick = st.tick;
endmodule: second_ticker

//--- hdl/value_tracker.sv
// Holds the highest (or lowest) sample since its last clear.
// Assumes the driver only asserts sample_valid for qualified samples.
`timescale 1ns/1ps
module value_tracker #(
   parameter bit IS_MAX = 1'b1,
   parameter bit IS_SIGNED = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   stat_trk_if.trk port
);
   typedef struct packed {
      logic signed [stats_pkg::MEAS_W-1:0] val;
      logic empty;
   } trk_state_t;
   trk_state_t st;
   trk_state_t next_st;
   logic better;

   // Currents use the full unsigned range, temperatures go negative
   function automatic logic signed [stats_pkg::MEAS_W:0] ext(
      input logic [stats_pkg::MEAS_W-1:0] x);
      return {IS_SIGNED && x[stats_pkg::MEAS_W-1], x};
   endfunction: ext

   // Compare against stored value; an empty tracker takes any sample
   always_comb begin
      next_st = st;
      if (port.clear) begin
         next_st.val = '0;
         next_st.empty = 1'b1;
      end
      better = IS_MAX ? (ext(port.sample) > ext(next_st.val))
                      : (ext(port.sample) < ext(next_st.val));
      // A sample beside a clear is kept, not lost
      if (port.sample_valid && (next_st.empty || better)) begin
         next_st.val = port.sample;
         next_st.empty = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '{val: '0, empty: 1'b1};
      end else begin
         st <= next_st;
      end
   end
   assign port.stored = st.val;

   // ****************************************
   // Assertions
   // ****************************************
   track_take_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port.sample_valid && !port.clear && !st.empty &&
      (IS_MAX ? ext(port.sample) > ext(st.val)
              : ext(port.sample) < ext(st.val))
      |=> port.stored == $past(port.sample))
      else $error("tracker missed a new extreme");
   track_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !port.clear && !st.empty && !(port.sample_valid &&
      (IS_MAX ? ext(port.sample) > ext(st.val)
              : ext(port.sample) < ext(st.val)))
      |=> $stable(port.stored))
      else $error("tracker changed without a new extreme");
endmodule: value_tracker

//--- bench/test_motor_run_statistics_recorder.sv
// Self-checking bench for the motor run statistics recorder.
// Assumes the recorder is built with a ten-cycle second for a short run.
`timescale 1ns/1ps
module test_motor_run_statistics_recorder;
   // ****************************************
   // Stimulus, outputs and bench state
   // ****************************************
   localparam int W = stats_pkg::MEAS_W;
   localparam int SECS = 10;
   localparam int LIMIT = 30000;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_start_begin = 1'b0;
   logic i_start_end = 1'b0, i_test_passed = 1'b0, i_inching = 1'b0;
   logic i_full_voltage = 1'b0, i_motor_running = 1'b0, i_fan_on = 1'b0;
   logic i_cur_valid = 1'b0, i_line_valid = 1'b0, i_energy_step = 1'b0;
   logic i_temp_valid = 1'b0, i_clear_strobe = 1'b0, i_scan_start = 1'b0;
   logic [W-1:0] i_cur_sample = '0, i_volt_sample = '0, i_freq_sample = '0;
   logic [W-1:0] i_scr_temp = '0;
   logic [6*W-1:0] i_motor_temp = '0;
   logic [3:0] i_statistics_clear_selector = 4'h0;
   logic [255:0] i_param_values = '0;
   logic [W-1:0] o_start_cur_max, o_start_cur_avg, o_fullv_cur_max;
   logic [W-1:0] o_volt_max, o_volt_min, o_freq_max, o_freq_min;
   logic [W-1:0] o_scr_temp_max;
   logic [6*W-1:0] o_motor_temp_max;
   logic [9:0] o_start_time_actual, o_start_time_final;
   logic [31:0] o_energy, o_powered_time;
   logic [31:0] o_motor_run_time_counter, o_fan_run_time_counter;
   logic [15:0] o_start_count;
   logic [3:0] o_changed_idx;
   logic o_changed_valid, o_scan_busy, o_scan_done;
   int fails = 0, samples_checked = 0, cyc = 0, rel = 0;
   int m, d, c, v, f, k, s, smax, vmax, vmin, fmax, fmin, cmax;
   int mt[6], mmax[6];
   logic [3:0] want[$], got[$];
   logic [15:0] pv;
   // ****************************************
   // Clock, timeout and device
   // ****************************************
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   // Cycle count doubles as the hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails++;
         tally_and_finish();
      end
   end
   motor_run_statistics_recorder #(.SEC_CYCLES(SECS)) u_dut (
      .i_clk, .i_nrst, .i_start_begin, .i_start_end, .i_test_passed,
      .i_inching, .i_full_voltage, .i_motor_running, .i_fan_on,
      .i_cur_valid, .i_cur_sample, .i_line_valid, .i_volt_sample,
      .i_freq_sample, .i_energy_step, .i_temp_valid, .i_scr_temp,
      .i_motor_temp, .i_statistics_clear_selector, .i_clear_strobe,
      .i_scan_start, .i_param_values, .o_start_cur_max, .o_start_cur_avg,
      .o_start_time_actual, .o_start_time_final, .o_fullv_cur_max,
      .o_volt_max, .o_volt_min, .o_freq_max, .o_freq_min, .o_energy,
      .o_start_count, .o_scr_temp_max, .o_motor_temp_max, .o_powered_time,
      .o_motor_run_time_counter, .o_fan_run_time_counter,
      .o_changed_valid, .o_changed_idx, .o_scan_busy, .o_scan_done);
   // ****************************************
   // Drivers and comparison
   // ****************************************
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask: check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask: tally_and_finish
   // Let the answering edge land before looking
   task automatic settle();
      @(posedge i_clk);
      #1;
   endtask: settle
   task automatic cur(input int x, input logic inch);
      @(posedge i_clk);
      {i_cur_valid, i_inching, i_cur_sample} <= {1'b1, inch, W'(x)};
      @(posedge i_clk);
      {i_cur_valid, i_inching} <= 2'b00;
   endtask: cur
   task automatic line(input int x, input int y);
      @(posedge i_clk);
      {i_line_valid, i_volt_sample, i_freq_sample} <= {1'b1, W'(x), W'(y)};
      @(posedge i_clk);
      i_line_valid <= 1'b0;
   endtask: line
   task automatic go(input logic tp);
      @(posedge i_clk);
      {i_start_begin, i_test_passed} <= {1'b1, tp};
      @(posedge i_clk);
      i_start_begin <= 1'b0;
   endtask: go
   task automatic fin();
      @(posedge i_clk);
      i_start_end <= 1'b1;
      @(posedge i_clk);
      i_start_end <= 1'b0;
      settle();
   endtask: fin
   task automatic clr(input logic [3:0] code);
      @(posedge i_clk);
      {i_clear_strobe, i_statistics_clear_selector} <= {1'b1, code};
      @(posedge i_clk);
      i_clear_strobe <= 1'b0;
      settle();
   endtask: clr
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      m = $urandom(32'hDD16FBAA);
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'b1;
      rel = cyc + 1;
      settle();
      check(o_start_count, 0);
      m = $urandom_range(140000, 1000);
      d = $urandom_range(900, 1);
      go(1'b1);
      cur(m - d, 1'b0);
      cur(m + d, 1'b0);
      cur(W'(18'h23820), 1'b1); // Inching sample must not count
      cur(m, 1'b0);
      settle();
      check(o_start_cur_max, m + d);
      check(o_start_cur_avg, m);
      check(o_start_count, 1);
      repeat (55) @(posedge i_clk);
      fin();
      check(1'(o_start_time_final inside {[5:7]}), 1);
      check(o_start_time_actual, 0);
      // Restart without a passed test, then run past the 999 s cap
      go(1'b0);
      settle();
      check({o_start_cur_max, o_start_time_final}, 0);
      check({o_start_cur_avg, o_start_time_actual}, 0);
      repeat (10100) @(posedge i_clk);
      fin();
      check(o_start_time_final, 999);
      check(o_start_count, 1);
      // Running at full voltage: extremes, energy and hours
      @(posedge i_clk);
      {i_motor_running, i_full_voltage, i_fan_on} <= 3'b111;
      {vmax, fmax, cmax} = {32'h0, 32'h0, 32'h0};
      {vmin, fmin} = {32'h1869F, 32'h270F};
      for (int i = 0; i < 6; i++) begin
         v = $urandom_range(9999, 100);
         f = $urandom_range(999, 400);
         c = $urandom_range(145440, 1);
         line(v, f);
         cur(c, 1'b0);
         {vmax, vmin} = {(v > vmax) ? v : vmax, (v < vmin) ? v : vmin};
         {fmax, fmin} = {(f > fmax) ? f : fmax, (f < fmin) ? f : fmin};
         cmax = (c > cmax) ? c : cmax;
      end
      k = $urandom_range(9, 3);
      repeat (k) begin
         @(posedge i_clk);
         i_energy_step <= 1'b1;
         @(posedge i_clk);
         i_energy_step <= 1'b0;
      end
      @(posedge i_clk);
      {i_motor_running, i_full_voltage, i_fan_on} <= 3'b000;
      line(W'(17'h1FFFF), 1); // Ignored while stopped
      settle();
      check({o_volt_max, o_volt_min}, {W'(vmax), W'(vmin)});
      check({o_freq_max, o_freq_min}, {W'(fmax), W'(fmin)});
      check(o_fullv_cur_max, cmax);
      check(o_start_cur_max, 0);
      check(o_energy, k);
      check(1'(o_motor_run_time_counter != 0), 1);
      check(1'(o_fan_run_time_counter != 0), 1);
      s = (cyc - rel) / SECS - int'(o_powered_time);
      check(1'(s inside {[-1:1]}), 1);
      // Signed temperatures, first round positive to seed the maxima
      for (int i = 0; i < 5; i++) begin
         s = (i == 0) ? $urandom_range(2600, 1)
                      : $urandom_range(2820, 0) - 220;
         smax = (i == 0 || s > smax) ? s : smax;
         for (int j = 0; j < 6; j++) begin
            mt[j] = (i == 0) ? $urandom_range(2600, 1)
                             : $urandom_range(2800, 0) - 200;
            mmax[j] = (i == 0 || mt[j] > mmax[j]) ? mt[j] : mmax[j];
            i_motor_temp[W*j +: W] <= W'(mt[j]);
         end
         {i_temp_valid, i_scr_temp} <= {1'b1, W'(s)};
         @(posedge i_clk);
         i_temp_valid <= 1'b0;
         @(posedge i_clk);
      end
      settle();
      check(o_scr_temp_max, W'(smax));
      for (int j = 0; j < 6; j++) begin
         check(o_motor_temp_max[W*j +: W], W'(mmax[j]));
      end
      // Clear codes: unknown, 6, 5, then 7
      clr(4'h4);
      check(o_energy, k);
      clr(stats_pkg::CLR_SCR);
      check(o_scr_temp_max, 0);
      check(o_volt_max, vmax);
      clr(stats_pkg::CLR_STATS);
      check({o_volt_max, o_volt_min, o_freq_max, o_freq_min}, 0);
      check({o_fullv_cur_max, o_energy}, 0);
      check(o_motor_temp_max, 0);
      check(o_start_count, 1);
      clr(stats_pkg::CLR_HOURS);
      check(o_motor_run_time_counter | o_fan_run_time_counter, 0);
      check(1'(o_powered_time > 900), 1);
      // Changed-parameter scan against the factory table
      for (int p = 0; p < 16; p++) begin
         pv = stats_pkg::FACTORY_DEFAULT[p];
         if ($urandom_range(1, 0) == 1) begin
            pv = pv ^ 16'($urandom_range(65535, 1));
            want.push_back(4'(p));
         end
         i_param_values[16*p +: 16] <= pv;
      end
      @(posedge i_clk);
      i_scan_start <= 1'b1;
      @(posedge i_clk);
      i_scan_start <= 1'b0;
      for (int t = 0; t < 40 && o_scan_done !== 1'b1; t++) begin
         settle();
         if (o_changed_valid === 1'b1) got.push_back(o_changed_idx);
      end
      check(o_scan_done, 1);
      check(o_scan_busy, 0);
      check(got.size(), want.size());
      foreach (want[i]) check(got[i], want[i]);
      tally_and_finish();
   end
endmodule: test_motor_run_statistics_recorder
